// ===== common/happ_consts.svh
// Shared constants for the host access port with prefetch.
// Assumes one system clock; quarter cycles are derived inside the port.
`ifndef HAPP_CONSTS_SVH
`define HAPP_CONSTS_SVH
`define HAPP_ADDR_W        27
`define HAPP_DATA_W        32
`define HAPP_ADDR_INC      27'h0000001
`define HAPP_MODE_RANDOM   2'h0
`define HAPP_MODE_BLOCK    2'h1
`define HAPP_MODE_RMW      2'h2
`define HAPP_Q1            2'h0
`define HAPP_Q2            2'h1
`define HAPP_Q3            2'h2
`define HAPP_Q4            2'h3
`define HAPP_IO_BASE       27'h7fff000
`define HAPP_IO_MASK       27'h7fff000
`endif

// ===== common/happ_pkg.sv
// Types for the host access port with prefetch.
// Assumes happ_consts.svh is compiled alongside.
`include "happ_consts.svh"
package happ_pkg;
	typedef struct packed
	{
		logic                    chip_select_n;
		logic                    read_strobe_n;
		logic                    write_strobe_n;
		logic [`HAPP_ADDR_W-1:0] address;
		logic [3:0]              byte_select;
	} happ_host_req_t;

	typedef struct packed
	{
		logic                    cyc_req;
		logic                    cyc_write;
		logic                    cyc_io;
		logic [`HAPP_ADDR_W-1:0] cyc_addr;
	} happ_mem_req_t;

	typedef enum logic [4:0]
	{
		HAPP_IDLE  = 5'h01,
		HAPP_WAIT  = 5'h02,
		HAPP_MEM   = 5'h04,
		HAPP_READY = 5'h08,
		HAPP_FETCH = 5'h10
	} happ_state_t;
endpackage : happ_pkg

// ===== core/happ_quarter.sv
// Quarter-cycle sequencer: one system clock per quarter, Q1..Q4.
// Assumes synchronous reset; Q1 follows reset release.
`timescale 1ns/100ps
`include "happ_consts.svh"
module happ_quarter
(
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	output logic [1:0]      quarter_o,
	output logic            q4_start_o
);
	typedef struct packed
	{
		logic [1:0] q;
	} happ_qstate_t;

	happ_qstate_t st;
	happ_qstate_t next_st;

	always_comb
	begin
		next_st   = st;
		next_st.q = st.q + 2'h1;
		if (reset_i)
		begin
			next_st.q = `HAPP_Q1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		st <= next_st;
	end

	assign quarter_o  = st.q;
	assign q4_start_o = (st.q == `HAPP_Q4);

	a_quarter_wraps : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.q == `HAPP_Q4 |=> st.q == `HAPP_Q1)
		else $error("quarter did not wrap to Q1");
endmodule : happ_quarter

// ===== core/happ_addr_match.sv
// Address compare for prefetch hits and internal register decode.
// Assumes addresses are stable for the cycle they are sampled in.
`timescale 1ns/100ps
`include "happ_consts.svh"
module happ_addr_match
(
	input  wire logic [`HAPP_ADDR_W-1:0] req_addr_i,
	input  wire logic [`HAPP_ADDR_W-1:0] pf_addr_i,
	input  wire logic                    pf_valid_i,
	output logic                         pf_hit_o,
	output logic                         io_hit_o
);
	function automatic logic is_io(input logic [`HAPP_ADDR_W-1:0] a);
		is_io = ((a & `HAPP_IO_MASK) == `HAPP_IO_BASE);
	endfunction : is_io

	assign pf_hit_o = pf_valid_i && (req_addr_i == pf_addr_i);
	assign io_hit_o = is_io(req_addr_i);
endmodule : happ_addr_match

// ===== core/happ_port.sv
// Host access port: host strobes to local-memory cycles with prefetch.
// Assumes host pins synchronous to sys_clk_i; memory answers with mem_done_i.
//
// What this block does
// - Pending host request is sampled at Q4; memory cycle begins next Q1.
// - A request missing the Q4 sample waits for the following Q4.
// - Read: ready rises at Q2; data strobe rises at Q4 to latch data.
// - Block mode: read next sequential word once host withdraws its read.
// - Block mode: each read strobe or chip select release ending a read starts a prefetch.
// - Host address equal to prefetched address gives ready at once.
// - Read-modify-write mode: read accessed word once the write request drops.
// - Internal register reads suppress transfer enable and column strobe.
// - Internal register reads assert the output data buffer enable.
// - Internal register access works in all three modes.
// - First write with none in progress gets ready immediately.
// - Second write waits for ready until the first memory write completes.
// - Input data buffer enable stays active through every host write.
// - Write: ready at Q2; write flag drops at Q4, strobes return high on mem_done_i.
`timescale 1ns/100ps
`include "happ_consts.svh"
module happ_port
#(
	parameter int ADDR_W = `HAPP_ADDR_W
)
(
	input  wire logic                    sys_clk_i,
	input  wire logic                    reset_i,
	input  happ_pkg::happ_host_req_t     host_req_i,
	input  wire logic [1:0]              mode_i,
	input  wire logic                    mem_done_i,
	output logic                         host_ready_o,
	output logic                         host_data_strobe_o,
	output logic                         host_output_enable_n_o,
	output logic                         address_latch_strobe_n_o,
	output logic                         column_strobe_n_o,
	output logic                         transfer_output_enable_n_o,
	output logic                         data_buffer_out_enable_n_o,
	output logic                         data_buffer_in_enable_n_o,
	output happ_pkg::happ_mem_req_t      mem_req_o
);
	initial
	begin
		if (ADDR_W != `HAPP_ADDR_W)
		begin
			$error("ADDR_W must match the shared address width");
		end
	end

	typedef struct packed
	{
		happ_pkg::happ_state_t   fsm;
		logic                    ready;
		logic                    dstrobe;
		logic                    hoe_n;
		logic                    address_latch_strobe_n;
		logic                    cas_n;
		logic                    trqe_n;
		logic                    data_buffer_out_enable_n;
		logic                    data_buffer_in_enable_n;
		logic                    wr_busy;
		logic                    is_write;
		logic                    is_io;
		logic                    pf_valid;
		logic                    pf_busy;
		logic [ADDR_W-1:0]       pf_addr;
		logic [ADDR_W-1:0]       cur_addr;
		logic                    prev_active;
		logic                    prev_wr;
		happ_pkg::happ_mem_req_t mreq;
	} happ_port_t;

	happ_port_t st;
	happ_port_t next_st;

	logic [1:0] quarter;
	logic       q4_start;
	logic       pf_hit;
	logic       io_hit;
	logic       active;
	logic       rd_req;
	logic       wr_req;
	logic       release_ev;

	happ_quarter u_quarter
	(
		.sys_clk_i  (sys_clk_i),
		.reset_i    (reset_i),
		.quarter_o  (quarter),
		.q4_start_o (q4_start)
	);

	happ_addr_match u_match
	(
		.req_addr_i (host_req_i.address),
		.pf_addr_i  (st.pf_addr),
		.pf_valid_i (st.pf_valid),
		.pf_hit_o   (pf_hit),
		.io_hit_o   (io_hit)
	);

	assign rd_req     = !host_req_i.chip_select_n && !host_req_i.read_strobe_n;
	assign wr_req     = !host_req_i.chip_select_n && !host_req_i.write_strobe_n;
	assign active     = rd_req || wr_req;
	assign release_ev = st.prev_active && !active;

	always_comb
	begin
		next_st             = st;
		next_st.prev_active = active;
		next_st.prev_wr     = wr_req;
		next_st.dstrobe     = 1'b0;
		next_st.mreq.cyc_req = 1'b0;
		if (mem_done_i)
		begin
			next_st.wr_busy = 1'b0;
			next_st.pf_busy = 1'b0;
			next_st.address_latch_strobe_n = 1'b1;
			next_st.cas_n   = 1'b1;
			next_st.hoe_n   = 1'b1;
			next_st.trqe_n  = 1'b1;
		end
		// Release is seen only while ready is still up; by IDLE the edge has passed
		if (release_ev && st.fsm == happ_pkg::HAPP_READY)
		begin
			next_st.ready   = 1'b0;
			next_st.data_buffer_out_enable_n = 1'b1;
			next_st.data_buffer_in_enable_n  = 1'b1;
			if (mode_i == `HAPP_MODE_BLOCK && !st.is_write)
			begin
				// Next sequential word fetched while the host is away
				next_st.pf_addr = st.cur_addr + `HAPP_ADDR_INC;
				next_st.pf_valid = 1'b1;
				next_st.pf_busy  = 1'b1;
				next_st.mreq     = '{1'b1, 1'b0, 1'b0, st.cur_addr + `HAPP_ADDR_INC};
			end
			else if (mode_i == `HAPP_MODE_RMW && st.is_write)
			begin
				next_st.pf_addr  = st.cur_addr;
				next_st.pf_valid = 1'b1;
				next_st.pf_busy  = 1'b1;
				next_st.mreq     = '{1'b1, 1'b0, 1'b0, st.cur_addr};
			end
		end
		unique case (st.fsm)
			happ_pkg::HAPP_IDLE:
			begin
				// Late requests simply stay pending until the next Q4
				if (active && q4_start)
				begin
					next_st.cur_addr = host_req_i.address;
					next_st.is_write = wr_req;
					next_st.is_io    = io_hit;
					next_st.fsm      = happ_pkg::HAPP_WAIT;
				end
			end
			happ_pkg::HAPP_WAIT:
			begin
				if (st.is_write)
				begin
					next_st.data_buffer_in_enable_n = 1'b0;
					if (!st.wr_busy)
					begin
						next_st.ready    = 1'b1;
						next_st.wr_busy  = 1'b1;
						next_st.pf_valid = 1'b0;
						next_st.mreq     = '{1'b1, 1'b1, st.is_io, st.cur_addr};
						next_st.address_latch_strobe_n  = 1'b0;
						next_st.cas_n    = st.is_io;
						next_st.hoe_n    = 1'b0;
						next_st.fsm      = happ_pkg::HAPP_READY;
					end
				end
				else if (!st.pf_busy)
				begin
					if (pf_hit && !st.is_io)
					begin
						next_st.ready = 1'b1;
						next_st.fsm   = happ_pkg::HAPP_READY;
					end
					else
					begin
						// Stale prefetch dropped; fresh access holds ready low
						next_st.pf_valid = 1'b0;
						next_st.mreq     = '{1'b1, 1'b0, st.is_io, st.cur_addr};
						next_st.address_latch_strobe_n  = 1'b0;
						next_st.cas_n    = st.is_io;
						next_st.trqe_n   = st.is_io;
						next_st.data_buffer_out_enable_n  = !st.is_io;
						next_st.fsm      = happ_pkg::HAPP_MEM;
					end
				end
			end
			happ_pkg::HAPP_MEM:
			begin
				if (mem_done_i && quarter == `HAPP_Q1)
				begin
					next_st.ready = 1'b1;
					next_st.fsm   = happ_pkg::HAPP_READY;
				end
				else if (mem_done_i)
				begin
					next_st.fsm = happ_pkg::HAPP_FETCH;
				end
			end
			happ_pkg::HAPP_FETCH:
			begin
				if (quarter == `HAPP_Q1)
				begin
					next_st.ready = 1'b1;
					next_st.fsm   = happ_pkg::HAPP_READY;
				end
			end
			happ_pkg::HAPP_READY:
			begin
				if (!st.is_write && quarter == `HAPP_Q3)
				begin
					next_st.dstrobe = 1'b1;
				end
				// Host drops chip select on ready; we wait for that release
				if (!active)
				begin
					next_st.fsm = happ_pkg::HAPP_IDLE;
				end
			end
			default:
			begin
				next_st.fsm = happ_pkg::HAPP_IDLE;
			end
		endcase
		if (st.wr_busy && st.mreq.cyc_write && quarter == `HAPP_Q3)
		begin
			next_st.mreq.cyc_write = 1'b0;
		end
		if (reset_i)
		begin
			next_st         = '0;
			next_st.fsm     = happ_pkg::HAPP_IDLE;
			next_st.hoe_n   = 1'b1;
			next_st.address_latch_strobe_n = 1'b1;
			next_st.cas_n   = 1'b1;
			next_st.trqe_n  = 1'b1;
			next_st.data_buffer_out_enable_n = 1'b1;
			next_st.data_buffer_in_enable_n  = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		st <= next_st;
	end

	assign host_ready_o               = st.ready;
	assign host_data_strobe_o         = st.dstrobe;
	assign host_output_enable_n_o     = st.hoe_n;
	assign address_latch_strobe_n_o   = st.address_latch_strobe_n;
	assign column_strobe_n_o          = st.cas_n;
	assign transfer_output_enable_n_o = st.trqe_n;
	assign data_buffer_out_enable_n_o = st.data_buffer_out_enable_n;
	assign data_buffer_in_enable_n_o  = st.data_buffer_in_enable_n;
	assign mem_req_o                  = st.mreq;

	a_io_no_cas : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.fsm == happ_pkg::HAPP_MEM && st.is_io && !st.is_write |-> st.cas_n && st.trqe_n)
		else $error("column strobe active on register read");
	a_io_buf_out : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.fsm == happ_pkg::HAPP_MEM && st.is_io && !st.is_write |-> !st.data_buffer_out_enable_n)
		else $error("out buffer not enabled on register read");
	a_wr_buf_in : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.fsm == happ_pkg::HAPP_READY && st.is_write |-> !st.data_buffer_in_enable_n)
		else $error("in buffer idle during write");
	a_req_at_q4 : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$rose(st.fsm == happ_pkg::HAPP_WAIT) |-> $past(q4_start))
		else $error("request taken outside Q4");
	a_wr_first_ready : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.fsm == happ_pkg::HAPP_WAIT && st.is_write && !st.wr_busy |=> st.ready)
		else $error("write ready not immediate");
	a_wr_hold_ready : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.fsm == happ_pkg::HAPP_WAIT && st.is_write && st.wr_busy && !mem_done_i |=> !st.ready)
		else $error("ready given while write busy");
	a_pf_hit_ready : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.fsm == happ_pkg::HAPP_WAIT && !st.is_write && !st.pf_busy && pf_hit && !st.is_io
		|=> st.ready ##0 st.fsm == happ_pkg::HAPP_READY)
		else $error("prefetch hit did not give ready");
	a_miss_no_ready : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.fsm == happ_pkg::HAPP_MEM |-> !st.ready)
		else $error("ready before miss access completes");
	a_strobe_q4 : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		st.dstrobe |-> quarter == `HAPP_Q4)
		else $error("data strobe outside Q4");
	a_blk_prefetch : assert property (@(posedge sys_clk_i) disable iff (reset_i)
		release_ev && st.fsm == happ_pkg::HAPP_READY && mode_i == `HAPP_MODE_BLOCK && !st.is_write
		|=> mem_req_o.cyc_req && mem_req_o.cyc_addr == $past(st.cur_addr) + `HAPP_ADDR_INC)
		else $error("block prefetch not started");
endmodule : happ_port

// ===== bench/happ_host_model.sv
// Host model: drives host strobes and answers local memory cycles.
// Assumes the port's clock; memory replies a set number of cycles after each cycle request.
`timescale 1ns/100ps
module happ_host_model
(
	input  wire logic                sys_clk_i,
	input  wire logic                host_ready_i,
	input  happ_pkg::happ_mem_req_t  mem_req_i,
	output happ_pkg::happ_host_req_t host_req_o,
	output logic                     mem_done_o
);
	int lat;
	int cnt;
	initial
	begin
		lat = 4;
		cnt = 0;
		mem_done_o = 1'b0;
		host_req_o = '{1'b1, 1'b1, 1'b1, 27'h0, 4'h0};
	end
	// A new cycle request restarts the count, so a late reply never leaks into the next cycle
	always @(posedge sys_clk_i)
	begin
		mem_done_o <= (cnt == 1) && !mem_req_i.cyc_req;
		if (mem_req_i.cyc_req)
			cnt <= lat;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	// Request held until two cycles after ready is sampled, then released; address inverted once released
	task access(input logic wr, input logic [26:0] a, output int w);
		host_req_o <= '{1'b0, wr, !wr, a, 4'hf};
		w = 0;
		do
		begin
			@(posedge sys_clk_i);
			w++;
		end
		while (host_ready_i !== 1'b1 && w < 200);
		repeat (2) @(posedge sys_clk_i);
		host_req_o <= '{1'b1, 1'b1, 1'b1, ~a, 4'h0};
		// Let the port see the release before any next request
		@(posedge sys_clk_i);
	endtask : access
endmodule : happ_host_model

// ===== bench/happ_port_test.sv
// Testbench for the host access port: host model on the host pins, monitors on the memory side.
// Assumes a 200 MHz clock and the quarter sequencer starting at Q1 after reset.
`timescale 1ns/100ps
`include "happ_consts.svh"
module happ_port_test;
	logic                     sys_clk_i;
	logic                     reset_i;
	logic [1:0]               mode_i;
	happ_pkg::happ_host_req_t host_req;
	happ_pkg::happ_mem_req_t  mreq;
	logic                     mem_done;
	logic                     rdy, host_data_strobe, hoe_n, alt_n, col_n, te_n, dbo_n, dbi_n;
	logic                     rdy_q, alt_q, seen_mem, seen_dbo, seen_dbi, m_wr, m_io;
	logic [26:0]              m_addr;
	int                       cyc, t_rdy, t_host_data_strobe, t_alt, w, n_fail, n_compared;

	happ_port dut
	(
		.sys_clk_i                  (sys_clk_i),
		.reset_i                    (reset_i),
		.host_req_i                 (host_req),
		.mode_i                     (mode_i),
		.mem_done_i                 (mem_done),
		.host_ready_o               (rdy),
		.host_data_strobe_o         (host_data_strobe),
		.host_output_enable_n_o     (hoe_n),
		.address_latch_strobe_n_o   (alt_n),
		.column_strobe_n_o          (col_n),
		.transfer_output_enable_n_o (te_n),
		.data_buffer_out_enable_n_o (dbo_n),
		.data_buffer_in_enable_n_o  (dbi_n),
		.mem_req_o                  (mreq)
	);
	happ_host_model host
	(
		.sys_clk_i    (sys_clk_i),
		.host_ready_i (rdy),
		.mem_req_i    (mreq),
		.host_req_o   (host_req),
		.mem_done_o   (mem_done)
	);

	initial
	begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		rdy_q <= rdy;
		alt_q <= alt_n;
		if (rdy && !rdy_q)
			t_rdy <= cyc;
		if (host_data_strobe)
			t_host_data_strobe <= cyc;
		if (alt_n && !alt_q)
			t_alt <= cyc;
		if (mreq.cyc_req)
		begin
			m_addr <= mreq.cyc_addr;
			m_wr <= mreq.cyc_write;
			m_io <= mreq.cyc_io;
		end
		if (!te_n || !col_n)
			seen_mem <= 1'b1;
		if (!dbo_n)
			seen_dbo <= 1'b1;
		if (!dbi_n)
			seen_dbi <= 1'b1;
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task ok(input string what, input logic cond);
		check(what, {31'h0, cond}, 32'h1);
	endtask : ok

	// Clearing off the edge keeps it apart from the monitor's updates
	task clear(input logic [1:0] m, input int l);
		@(negedge sys_clk_i);
		seen_mem = 1'b0;
		seen_dbo = 1'b0;
		seen_dbi = 1'b0;
		m_addr = 27'h0;
		host.lat = l;
		mode_i <= m;
		@(posedge sys_clk_i);
	endtask : clear

	task t_writes;
		clear(`HAPP_MODE_RANDOM, 30);
		host.access(1'b1, 27'h0000100, w);
		ok("first write ready", w <= 7);
		ok("input buffer enable", seen_dbi);
		host.access(1'b1, 27'h0000101, w);
		ok("second write held", w >= 15);
		repeat (40) @(posedge sys_clk_i);
		ok("write strobes high", alt_n && hoe_n && col_n);
		$display("test writes done");
	endtask : t_writes

	task t_read_miss;
		clear(`HAPP_MODE_RANDOM, 10);
		host.access(1'b0, 27'h0000200, w);
		ok("miss wait", w >= 13);
		check("miss addr", m_addr, 27'h0000200);
		check("data strobe", t_host_data_strobe - t_rdy, 32'h2);
		repeat (20) @(posedge sys_clk_i);
		$display("test read miss done");
	endtask : t_read_miss

	task t_block;
		clear(`HAPP_MODE_BLOCK, 6);
		host.access(1'b0, 27'h0000300, w);
		ok("block miss", w >= 10);
		repeat (20) @(posedge sys_clk_i);
		check("prefetch addr", m_addr, 27'h0000301);
		ok("prefetch read", !m_wr);
		host.access(1'b0, 27'h0000301, w);
		ok("prefetch hit", w <= 7);
		repeat (20) @(posedge sys_clk_i);
		check("second prefetch", m_addr, 27'h0000302);
		host.access(1'b0, 27'h0000310, w);
		ok("prefetch miss", w >= 10);
		repeat (20) @(posedge sys_clk_i);
		$display("test block done");
	endtask : t_block

	task t_rmw;
		clear(`HAPP_MODE_RMW, 4);
		host.access(1'b1, 27'h0000400, w);
		repeat (12) @(posedge sys_clk_i);
		check("rmw read addr", m_addr, 27'h0000400);
		ok("rmw read", !m_wr);
		repeat (20) @(posedge sys_clk_i);
		$display("test rmw done");
	endtask : t_rmw

	task t_io;
		for (int m = 0; m < 3; m++)
		begin
			clear(m[1:0], 4);
			host.access(1'b0, 27'h7fff004, w);
			ok("io no memory strobes", !seen_mem);
			ok("io out buffer", seen_dbo);
			ok("io cycle flag", m_io);
			repeat (20) @(posedge sys_clk_i);
		end
		$display("test io done");
	endtask : t_io

	task conclude;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	initial
	begin
		#20000;
		n_fail++;
		conclude();
	end

	initial
	begin
		cyc = 0;
		n_fail = 0;
		n_compared = 0;
		reset_i = 1'b1;
		mode_i = `HAPP_MODE_RANDOM;
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		t_writes();
		t_read_miss();
		t_block();
		t_rmw();
		t_io();
		conclude();
	end
endmodule : happ_port_test
